/* File: dv/host_model.sv */
// Host controller model: register requests of the FIFO control block
module host_model (
  input  wire logic               sys_clk,
  input  wire logic [7:0]         reg_rdata,
  output uart_fifo_pkg::reg_req_s reg_req,
  output logic                    line_ctrl_dlab,
  output logic                    enh_func_en
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_req = '0;
    line_ctrl_dlab = 1'b0;
    enh_func_en = 1'b0;
  end
  task automatic mode(input logic dlab, input logic enh);
    @(negedge sys_clk);
    line_ctrl_dlab = dlab;
    enh_func_en = enh;
  endtask : mode
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge sys_clk);
    d = reg_rdata;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
  endtask : rd
endmodule : host_model

/* File: dv/uart_fifo_control_checker.sv */
// Checker: port assertions of the FIFO control block
module uart_fifo_control_checker #(
  parameter int GPIO_W = 8
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire uart_fifo_pkg::reg_req_s       reg_req,
  input wire logic                          line_ctrl_dlab,
  input wire logic                          enh_func_en,
  input wire uart_fifo_pkg::flow_event_s    flow_event,
  input wire logic [GPIO_W-1:0]             gpio_in,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          reg_rvalid,
  input wire uart_fifo_pkg::fifo_control_s  fifo_control_reg,
  input wire logic [7:0]                    interrupt_ident_reg,
  input wire logic [6:0]                    rx_trigger_level,
  input wire logic [6:0]                    tx_trigger_level,
  input wire logic [6:0]                    fifo_capacity,
  input wire logic                          tx_fifo_flush,
  input wire logic                          rx_fifo_flush
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wr_ok = reg_req.wr && reg_req.addr == uart_fifo_pkg::FIFO_CONTROL_OFS && !line_ctrl_dlab;
  wire flushing = tx_fifo_flush || rx_fifo_flush;
  wire tx_again = wr_ok && reg_req.wdata[0] && reg_req.wdata[2];
  wire rx_again = wr_ok && reg_req.wdata[0] && reg_req.wdata[1];
  function automatic logic [6:0] rx_lvl(input logic [1:0] c);
    return c[1] ? (c[0] ? uart_fifo_pkg::RX_TRIG_CODE3 : uart_fifo_pkg::RX_TRIG_CODE2)
                : (c[0] ? uart_fifo_pkg::RX_TRIG_CODE1 : uart_fifo_pkg::RX_TRIG_CODE0);
  endfunction : rx_lvl
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Assertions
  // ****************************************
  AST_RD_ANSWER: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  AST_TX_SELFCLR: assert property (tx_fifo_flush && !tx_again
    |=> !tx_fifo_flush && !fifo_control_reg.tx_reset)
    else $error("tx reset stuck");
  AST_RX_SELFCLR: assert property (rx_fifo_flush && !rx_again
    |=> !rx_fifo_flush && !fifo_control_reg.rx_reset)
    else $error("rx reset stuck");
  AST_FLUSH: assert property (wr_ok && reg_req.wdata[0]
    |=> tx_fifo_flush == $past(reg_req.wdata[2]) && rx_fifo_flush == $past(reg_req.wdata[1]))
    else $error("flush mismatch");
  AST_RX_TRIG: assert property (wr_ok && reg_req.wdata[0]
    |=> rx_trigger_level == rx_lvl($past(reg_req.wdata[7:6])))
    else $error("rx trigger wrong");
  AST_CAPACITY: assert property (fifo_capacity ==
    (fifo_control_reg.fifo_en ? uart_fifo_pkg::FIFO_DEPTH : uart_fifo_pkg::HOLD_NO_FIFO))
    else $error("capacity wrong");
  AST_REFUSED: assert property (reg_req.wr && !wr_ok && !flushing
    |=> $stable(fifo_control_reg))
    else $error("refused write took effect");
  AST_TX_LOCK: assert property (wr_ok && !enh_func_en
    |=> $stable(fifo_control_reg.tx_trig))
    else $error("tx trigger changed while locked");
  AST_XOFF: assert property (flow_event.xoff_detect |-> ##2 interrupt_ident_reg[4])
    else $error("xoff not identified");
  AST_RSVD: assert property (fifo_control_reg.reserved == 1'b0)
    else $error("reserved bit set");
  cover property (wr_ok && reg_req.wdata[2]);
  cover property (flow_event.xon_detect);
  cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule : uart_fifo_control_checker

/* File: dv/uart_fifo_control_tb.sv */
// Testbench: FIFO control register and identification sources
module uart_fifo_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          sys_clk = 1'b0;
  logic                          rst_n;
  uart_fifo_pkg::reg_req_s       reg_req;
  logic                          dlab, enh, reg_rvalid, tx_fifo_flush, rx_fifo_flush;
  uart_fifo_pkg::flow_event_s    flow_event;
  logic [7:0]                    gpio_in, reg_rdata, interrupt_ident_reg, d;
  uart_fifo_pkg::fifo_control_s  fifo_control;
  logic [6:0]                    rx_lvl, tx_lvl, cap;
  int                            err_total = 0;
  int                            tests_run = 0;
  int                            cycles = 0;
  logic [6:0] rx_t[4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  logic [6:0] tx_t[4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  always #2 sys_clk = ~sys_clk;
  uart_fifo_control i_uart_fifo_control (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .line_ctrl_dlab(dlab), .enh_func_en(enh), .flow_event(flow_event), .gpio_in(gpio_in),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fifo_control_reg(fifo_control),
    .interrupt_ident_reg(interrupt_ident_reg), .rx_trigger_level(rx_lvl),
    .tx_trigger_level(tx_lvl), .fifo_capacity(cap), .tx_fifo_flush(tx_fifo_flush),
    .rx_fifo_flush(rx_fifo_flush));
  host_model i_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .line_ctrl_dlab(dlab), .enh_func_en(enh));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic ev(input logic [3:0] v, input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] r;
    @(negedge sys_clk);
    flow_event = v;
    @(negedge sys_clk);
    flow_event = '0;
    repeat (2) @(negedge sys_clk);
    chk("ident_reg", e1, interrupt_ident_reg);
    i_host_model.rd(4'h2, r);
    chk("ident", e1, r);
    i_host_model.rd(4'h2, r);
    chk("ident_again", e2, r);
  endtask : ev
  task automatic results;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    flow_event = '0;
    gpio_in = 8'h00;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("fcr", 8'h00, fifo_control);
    chk("cap", 8'h01, {1'b0, cap});
    i_host_model.mode(1'b0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      i_host_model.wr(4'h2, {c[1:0], c[1:0], 4'h9});
      chk("fcr", {c[1:0], c[1:0], 4'h1}, fifo_control);
      chk("rx_trig", {1'b0, rx_t[c]}, {1'b0, rx_lvl});
      chk("tx_trig", {1'b0, tx_t[c]}, {1'b0, tx_lvl});
      chk("cap", 8'h40, {1'b0, cap});
    end
    i_host_model.wr(4'h2, 8'h07);
    chk("flush", 8'h03, {6'h00, tx_fifo_flush, rx_fifo_flush});
    @(negedge sys_clk);
    chk("flush_end", 8'h00, {6'h00, tx_fifo_flush, rx_fifo_flush});
    chk("fcr", 8'h01, fifo_control);
    i_host_model.wr(4'h2, 8'hF1);
    i_host_model.mode(1'b0, 1'b0);
    i_host_model.wr(4'h2, 8'h01);
    chk("fcr", 8'h31, fifo_control);
    i_host_model.mode(1'b1, 1'b1);
    i_host_model.wr(4'h2, 8'hC1);
    chk("fcr", 8'h31, fifo_control);
    i_host_model.rd(4'h2, d);
    chk("rd_blocked", 8'h00, d);
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    i_host_model.mode(1'b0, 1'b1);
    i_host_model.wr(4'h5, 8'hC1);
    chk("fcr", 8'h31, fifo_control);
    i_host_model.wr(4'h2, 8'hC6);
    chk("flush", 8'h00, {6'h00, tx_fifo_flush, rx_fifo_flush});
    chk("rx_trig", 8'h01, {1'b0, rx_lvl});
    chk("tx_trig", 8'h01, {1'b0, tx_lvl});
    chk("cap", 8'h01, {1'b0, cap});
    ev(4'b1000, 8'h10, 8'h10);
    ev(4'b0100, 8'h01, 8'h01);
    ev(4'b0010, 8'h10, 8'h01);
    ev(4'b0001, 8'h20, 8'h01);
    gpio_in = 8'h5A;
    repeat (3) @(negedge sys_clk);
    ev(4'b0001, 8'h30, 8'h20);
    ev(4'b0000, 8'h01, 8'h01);
    results();
  end
endmodule : uart_fifo_control_tb
bind uart_fifo_control uart_fifo_control_checker #(.GPIO_W(GPIO_W)) i_uart_fifo_control_checker (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .line_ctrl_dlab(line_ctrl_dlab),
  .enh_func_en(enh_func_en), .flow_event(flow_event), .gpio_in(gpio_in),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fifo_control_reg(fifo_control_reg),
  .interrupt_ident_reg(interrupt_ident_reg), .rx_trigger_level(rx_trigger_level),
  .tx_trigger_level(tx_trigger_level), .fifo_capacity(fifo_capacity),
  .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush));

/* File: rtl/gpio_change_detect.sv */
// Synchroniser and change-of-state detector for the general-purpose inputs
module gpio_change_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic                  changed
);

  // ****************************************
  // Two-stage synchroniser and edge compare
  // ****************************************
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] last;
  logic             primed;

  wire              next_changed = primed && (sync_b != last);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a  <= '0;
      sync_b  <= '0;
      last    <= '0;
      primed  <= 1'b0;
      changed <= 1'b0;
    end else begin
      sync_a  <= pin_in;
      sync_b  <= sync_a;
      last    <= sync_b;
      primed  <= 1'b1;
      changed <= next_changed;
    end
  end

endmodule : gpio_change_detect

/* File: rtl/uart_fifo_control.sv */
// FIFO control register and late interrupt identification sources of the UART bridge
module uart_fifo_control #(
  parameter int GPIO_W = uart_fifo_pkg::GPIO_WIDTH
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire uart_fifo_pkg::reg_req_s     reg_req,
  input  wire logic                        line_ctrl_dlab,
  input  wire logic                        enh_func_en,
  input  wire uart_fifo_pkg::flow_event_s  flow_event,
  input  wire logic [GPIO_W-1:0]           gpio_in,
  output logic [7:0]                       reg_rdata,
  output logic                             reg_rvalid,
  output uart_fifo_pkg::fifo_control_s     fifo_control_reg,
  output logic [7:0]                       interrupt_ident_reg,
  output logic [6:0]                       rx_trigger_level,
  output logic [6:0]                       tx_trigger_level,
  output logic [6:0]                       fifo_capacity,
  output logic                             tx_fifo_flush,
  output logic                             rx_fifo_flush
);

  // ****************************************
  // Lookup functions
  // ****************************************
  function automatic logic [6:0] rx_trig_level(input logic [1:0] code);
    logic [6:0] lvl;
    lvl = uart_fifo_pkg::RX_TRIG_CODE0;
    unique case (code)
      2'h0: lvl = uart_fifo_pkg::RX_TRIG_CODE0;
      2'h1: lvl = uart_fifo_pkg::RX_TRIG_CODE1;
      2'h2: lvl = uart_fifo_pkg::RX_TRIG_CODE2;
      2'h3: lvl = uart_fifo_pkg::RX_TRIG_CODE3;
    endcase
    return lvl;
  endfunction : rx_trig_level

  function automatic logic [6:0] tx_trig_level(input logic [1:0] code);
    logic [6:0] lvl;
    lvl = uart_fifo_pkg::TX_TRIG_CODE0;
    unique case (code)
      2'h0: lvl = uart_fifo_pkg::TX_TRIG_CODE0;
      2'h1: lvl = uart_fifo_pkg::TX_TRIG_CODE1;
      2'h2: lvl = uart_fifo_pkg::TX_TRIG_CODE2;
      2'h3: lvl = uart_fifo_pkg::TX_TRIG_CODE3;
    endcase
    return lvl;
  endfunction : tx_trig_level

  // ****************************************
  // Address decode
  // ****************************************
  wire  fcr_hit = reg_req.addr == uart_fifo_pkg::FIFO_CONTROL_OFS;
  wire  iir_hit = reg_req.addr == uart_fifo_pkg::INTERRUPT_IDENT_OFS;
  wire  fcr_wr  = reg_req.wr && fcr_hit && !line_ctrl_dlab;
  wire  iir_rd  = reg_req.rd && iir_hit && !line_ctrl_dlab;
  uart_fifo_pkg::fifo_control_s wr_fcr;
  assign wr_fcr = uart_fifo_pkg::fifo_control_s'(reg_req.wdata);

  // ****************************************
  // FIFO control next value
  // ****************************************
  wire  fifo_on   = fcr_wr ? wr_fcr.fifo_en : fifo_control_reg.fifo_en;
  wire  prog_ok   = fcr_wr && wr_fcr.fifo_en;
  wire  tx_trig_w = prog_ok && enh_func_en;
  uart_fifo_pkg::fifo_control_s next_fcr;
  assign next_fcr.fifo_en  = fifo_on;
  assign next_fcr.rx_trig  = prog_ok ? wr_fcr.rx_trig : fifo_control_reg.rx_trig;
  assign next_fcr.tx_trig  = tx_trig_w ? wr_fcr.tx_trig : fifo_control_reg.tx_trig;
  assign next_fcr.reserved = 1'b0;
  // Reset bits are set by a write that also sets fifo_en and drop after one cycle of flushing
  assign next_fcr.tx_reset = prog_ok && wr_fcr.tx_reset;
  assign next_fcr.rx_reset = prog_ok && wr_fcr.rx_reset;

  wire [6:0] next_rx_lvl = fifo_on ? rx_trig_level(next_fcr.rx_trig)
                                   : uart_fifo_pkg::TRIG_NO_FIFO;
  wire [6:0] next_tx_lvl = fifo_on ? tx_trig_level(next_fcr.tx_trig)
                                   : uart_fifo_pkg::TRIG_NO_FIFO;
  wire [6:0] next_cap    = fifo_on ? uart_fifo_pkg::FIFO_DEPTH
                                   : uart_fifo_pkg::HOLD_NO_FIFO;

  // ****************************************
  // Interrupt source flags
  // ****************************************
  logic pin_flag;
  logic xoff_flag;
  logic spec_flag;
  logic modem_flag;
  logic pin_change;

  gpio_change_detect #(
    .WIDTH (GPIO_W)
  ) u_gpio_change (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (gpio_in),
    .changed (pin_change)
  );

  wire [5:0] cur_ident = pin_flag               ? uart_fifo_pkg::IDENT_PIN_CHANGE :
                         (xoff_flag | spec_flag) ? uart_fifo_pkg::IDENT_XOFF_SPEC  :
                         modem_flag             ? uart_fifo_pkg::IDENT_MODEM_OFF  :
                                                  uart_fifo_pkg::IDENT_NONE;
  wire  rd_pin   = iir_rd && pin_flag;
  wire  rd_modem = iir_rd && cur_ident == uart_fifo_pkg::IDENT_MODEM_OFF;

  // Setting events win over clears in the same cycle
  wire  next_pin   = pin_change | (pin_flag & ~rd_pin);
  wire  next_xoff  = flow_event.xoff_detect |
                     (xoff_flag & ~flow_event.xon_detect);
  wire  next_spec  = flow_event.special_detect | (spec_flag & ~iir_rd);
  wire  next_modem = flow_event.modem_inactive | (modem_flag & ~rd_modem);

  wire [7:0] next_rdata = (iir_hit && !line_ctrl_dlab) ? {uart_fifo_pkg::IDENT_TOP_BITS, cur_ident}
                                                       : uart_fifo_pkg::UNMAPPED_READ;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_control_reg <=
        uart_fifo_pkg::fifo_control_s'(uart_fifo_pkg::FIFO_CONTROL_RESET);
      rx_trigger_level <= uart_fifo_pkg::TRIG_NO_FIFO;
      tx_trigger_level <= uart_fifo_pkg::TRIG_NO_FIFO;
      fifo_capacity    <= uart_fifo_pkg::HOLD_NO_FIFO;
    end else begin
      fifo_control_reg <= next_fcr;
      rx_trigger_level <= next_rx_lvl;
      tx_trigger_level <= next_tx_lvl;
      fifo_capacity    <= next_cap;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_flag   <= 1'b0;
      xoff_flag  <= 1'b0;
      spec_flag  <= 1'b0;
      modem_flag <= 1'b0;
    end else begin
      pin_flag   <= next_pin;
      xoff_flag  <= next_xoff;
      spec_flag  <= next_spec;
      modem_flag <= next_modem;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata           <= uart_fifo_pkg::UNMAPPED_READ;
      reg_rvalid          <= 1'b0;
      interrupt_ident_reg <= {uart_fifo_pkg::IDENT_TOP_BITS, uart_fifo_pkg::IDENT_NONE};
    end else begin
      reg_rdata           <= reg_req.rd ? next_rdata : uart_fifo_pkg::UNMAPPED_READ;
      reg_rvalid          <= reg_req.rd;
      interrupt_ident_reg <= {uart_fifo_pkg::IDENT_TOP_BITS, cur_ident};
    end
  end

  // Flush strobes are the self-clearing reset bits themselves
  assign tx_fifo_flush = fifo_control_reg.tx_reset;
  assign rx_fifo_flush = fifo_control_reg.rx_reset;

endmodule : uart_fifo_control

/* File: rtl/uart_fifo_pkg.sv */
// Package: constants and carrier types for the UART FIFO control block
package uart_fifo_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] FIFO_CONTROL_OFS    = 4'h2;
  localparam logic [3:0] INTERRUPT_IDENT_OFS = 4'h2;
  localparam logic [7:0] FIFO_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // ****************************************
  // Trigger levels and FIFO capacities, in characters or spaces
  // ****************************************
  localparam logic [6:0] RX_TRIG_CODE0 = 7'h08;
  localparam logic [6:0] RX_TRIG_CODE1 = 7'h10;
  localparam logic [6:0] RX_TRIG_CODE2 = 7'h38;
  localparam logic [6:0] RX_TRIG_CODE3 = 7'h3C;
  localparam logic [6:0] TX_TRIG_CODE0 = 7'h08;
  localparam logic [6:0] TX_TRIG_CODE1 = 7'h10;
  localparam logic [6:0] TX_TRIG_CODE2 = 7'h20;
  localparam logic [6:0] TX_TRIG_CODE3 = 7'h38;
  localparam logic [6:0] TRIG_NO_FIFO  = 7'h01;
  localparam logic [6:0] FIFO_DEPTH    = 7'h40;
  localparam logic [6:0] HOLD_NO_FIFO  = 7'h01;

  // ****************************************
  // Interrupt identification codes, bits 5:0, and fixed bits 7:6
  // ****************************************
  localparam logic [5:0] IDENT_NONE       = 6'h01;
  localparam logic [5:0] IDENT_PIN_CHANGE = 6'h30;
  localparam logic [5:0] IDENT_XOFF_SPEC  = 6'h10;
  localparam logic [5:0] IDENT_MODEM_OFF  = 6'h20;
  localparam logic [1:0] IDENT_TOP_BITS   = 2'h0;

  // ****************************************
  // Widths
  // ****************************************
  localparam int GPIO_WIDTH = 8;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic       reserved;
    logic       tx_reset;
    logic       rx_reset;
    logic       fifo_en;
  } fifo_control_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic xoff_detect;
    logic xon_detect;
    logic special_detect;
    logic modem_inactive;
  } flow_event_s;

endpackage : uart_fifo_pkg
